// ### hw/serial_engine.sv
// Serial engine front end: tx buffer, two-deep rx buffer, baud enable, address match.
// Assumes rx pins and the external clock come from outside the clock domain.
`timescale 1ns/1ps
`include "serial_engine_map.svh"

module serial_engine
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // Configuration
  input  wire logic [`MODE_W-1:0]   mode,
  input  wire logic                 ext_clk_sel,
  input  wire logic                 ext_clk,
  input  wire logic [`BAUD_W-1:0]   baud_div,
  input  wire logic [`AMODE_W-1:0]  addr_mode,
  input  wire logic [`ADDR_W-1:0]   match_addr_field,
  input  wire logic [`ADDR_W-1:0]   match_mask_field,
  // Transmit word
  input  wire logic                 tx_valid,
  input  wire logic [`DATA_W-1:0]   tx_data,
  output logic                      tx_ready,
  output logic                      tx_line,
  // Receive line
  input  wire logic                 rx_line,
  input  wire logic                 rx_is_addr,
  // Receive word
  output logic                      rx_valid,
  output logic [`DATA_W-1:0]        rx_data,
  input  wire logic                 rx_pop,
  output logic                      rx_overflow,
  // Address result
  output logic                      addr_done,
  output logic                      addr_hit
);

  // ****************************************
  // Input synchronisers and baud enable
  // ****************************************
  logic [1:0] rx_sync_q, rx_sync_d;
  logic [1:0] ex_sync_q, ex_sync_d;
  logic       ex_prev_q, ex_prev_d;
  logic       isa_sync0_q, isa_sync1_q, isa_sync0_d, isa_sync1_d;
  logic [`BAUD_W-1:0] baud_cnt_q, baud_cnt_d;
  logic       tick;

  always_comb
  begin
    rx_sync_d   = {rx_sync_q[0], rx_line};
    ex_sync_d   = {ex_sync_q[0], ext_clk};
    ex_prev_d   = ex_sync_q[1];
    isa_sync0_d = rx_is_addr;
    isa_sync1_d = isa_sync0_q;
    baud_cnt_d  = baud_cnt_q;
    tick        = 1'b0;
    if (ext_clk_sel)
    begin
      tick = ex_sync_q[1] & ~ex_prev_q;
    end
    else if (baud_cnt_q >= baud_div)
    begin
      baud_cnt_d = `BAUD_RESET;
      tick       = 1'b1;
    end
    else
    begin
      baud_cnt_d = baud_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sync_q   <= 2'h3;
      ex_sync_q   <= 2'h0;
      ex_prev_q   <= 1'b0;
      isa_sync0_q <= 1'b0;
      isa_sync1_q <= 1'b0;
      baud_cnt_q  <= `BAUD_RESET;
    end
    else
    begin
      rx_sync_q   <= rx_sync_d;
      ex_sync_q   <= ex_sync_d;
      ex_prev_q   <= ex_prev_d;
      isa_sync0_q <= isa_sync0_d;
      isa_sync1_q <= isa_sync1_d;
      baud_cnt_q  <= baud_cnt_d;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  logic [`DATA_W-1:0]    txb_q, txb_d;
  logic                  txb_full_q, txb_full_d;
  logic [`DATA_W:0]      txs_q, txs_d;
  logic [`BIT_CNT_W-1:0] txc_q, txc_d;
  serial_engine_pkg::shift_state_t txst_q, txst_d;
  logic                  tx_line_q, tx_line_d;

  always_comb
  begin
    txb_d      = txb_q;
    txb_full_d = txb_full_q;
    txs_d      = txs_q;
    txc_d      = txc_q;
    txst_d     = txst_q;
    tx_line_d  = tx_line_q;
    // one word waits in the write buffer
    if (tx_valid && !txb_full_q)
    begin
      txb_d      = tx_data;
      txb_full_d = 1'b1;
    end
    unique case (txst_q)
      serial_engine_pkg::SH_IDLE:
      begin
        tx_line_d = 1'b1;
        if (txb_full_q && tick)
        begin
          // Start bit then data, lsb first
          txs_d      = {txb_q, 1'b0};
          txc_d      = 4'h0;
          txb_full_d = 1'b0;
          txst_d     = serial_engine_pkg::SH_BUSY;
        end
      end
      serial_engine_pkg::SH_BUSY:
      begin
        if (tick)
        begin
          tx_line_d = txs_q[0];
          txs_d     = {1'b1, txs_q[`DATA_W:1]};
          txc_d     = txc_q + 4'h1;
          if (txc_q == `TX_LAST_CNT)
          begin
            txst_d = serial_engine_pkg::SH_LAST;
          end
        end
      end
      serial_engine_pkg::SH_LAST:
      begin
        if (tick)
        begin
          // Stop bit
          tx_line_d = 1'b1;
          txst_d    = serial_engine_pkg::SH_IDLE;
        end
      end
      default: txst_d = serial_engine_pkg::SH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txb_q      <= 8'h00;
      txb_full_q <= 1'b0;
      txs_q      <= 9'h1FF;
      txc_q      <= 4'h0;
      txst_q     <= serial_engine_pkg::SH_IDLE;
      tx_line_q  <= 1'b1;
    end
    else
    begin
      txb_q      <= txb_d;
      txb_full_q <= txb_full_d;
      txs_q      <= txs_d;
      txc_q      <= txc_d;
      txst_q     <= txst_d;
      tx_line_q  <= tx_line_d;
    end
  end

  assign tx_line = tx_line_q;

  // ****************************************
  // Receive shift register
  // ****************************************
  logic [`DATA_W-1:0]    rxs_q, rxs_d;
  logic [`BIT_CNT_W-1:0] rxc_q, rxc_d;
  serial_engine_pkg::shift_state_t rxst_q, rxst_d;
  logic                  word_done;

  always_comb
  begin
    rxs_d     = rxs_q;
    rxc_d     = rxc_q;
    rxst_d    = rxst_q;
    word_done = 1'b0;
    unique case (rxst_q)
      serial_engine_pkg::SH_IDLE:
      begin
        if (tick && !rx_sync_q[1])
        begin
          rxc_d  = 4'h0;
          rxst_d = serial_engine_pkg::SH_BUSY;
        end
      end
      serial_engine_pkg::SH_BUSY:
      begin
        if (tick)
        begin
          rxs_d = {rx_sync_q[1], rxs_q[`DATA_W-1:1]};
          rxc_d = rxc_q + 4'h1;
          if (rxc_q == `RX_LAST_CNT)
          begin
            rxst_d = serial_engine_pkg::SH_LAST;
          end
        end
      end
      serial_engine_pkg::SH_LAST:
      begin
        if (tick)
        begin
          word_done = 1'b1;
          rxst_d    = serial_engine_pkg::SH_IDLE;
        end
      end
      default: rxst_d = serial_engine_pkg::SH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxs_q  <= 8'h00;
      rxc_q  <= 4'h0;
      rxst_q <= serial_engine_pkg::SH_IDLE;
    end
    else
    begin
      rxs_q  <= rxs_d;
      rxc_q  <= rxc_d;
      rxst_q <= rxst_d;
    end
  end

  // ****************************************
  // Two-level receive buffer
  // ****************************************
  logic [`DATA_W-1:0] rxbuf_q [2];
  logic [`DATA_W-1:0] rxbuf_d [2];
  logic [1:0]         rxn_q, rxn_d;
  logic               ovf_q, ovf_d;
  logic               data_word;

  always_comb
  begin
    rxbuf_d   = rxbuf_q;
    rxn_d     = rxn_q;
    ovf_d     = ovf_q;
    data_word = word_done && !isa_sync1_q;
    if (rx_pop && rxn_q != 2'h0)
    begin
      rxbuf_d[0] = rxbuf_q[1];
      rxn_d      = rxn_q - 2'h1;
    end
    if (data_word)
    begin
      if (rxn_d == 2'h2)
      begin
        ovf_d = 1'b1;
      end
      else
      begin
        rxbuf_d[rxn_d[0]] = rxs_q;
        rxn_d             = rxn_d + 2'h1;
      end
    end
    else if (rx_pop)
    begin
      ovf_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxbuf_q[0] <= 8'h00;
      rxbuf_q[1] <= 8'h00;
      rxn_q      <= 2'h0;
      ovf_q      <= 1'b0;
    end
    else
    begin
      rxbuf_q <= rxbuf_d;
      rxn_q   <= rxn_d;
      ovf_q   <= ovf_d;
    end
  end

  // ****************************************
  // Address match and outputs
  // ****************************************
  logic hit_raw;
  logic done_q, done_d;
  logic hit_q, hit_d;
  logic txr_q, txr_d;
  logic rxv_q, rxv_d;
  logic [`DATA_W-1:0] rxd_q, rxd_d;

  address_matcher u_match
  (
    .mode             (mode),
    .addr_mode        (addr_mode),
    .match_addr_field (match_addr_field),
    .match_mask_field (match_mask_field),
    .rx_addr          (rxs_q),
    .hit              (hit_raw)
  );

  always_comb
  begin
    done_d = word_done && isa_sync1_q;
    hit_d  = (word_done && isa_sync1_q) ? hit_raw : hit_q;
    txr_d  = !txb_full_d;
    rxv_d  = rxn_d != 2'h0;
    rxd_d  = rxbuf_d[0];
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_q <= 1'b0;
      hit_q  <= 1'b0;
      txr_q  <= 1'b1;
      rxv_q  <= 1'b0;
      rxd_q  <= 8'h00;
    end
    else
    begin
      done_q <= done_d;
      hit_q  <= hit_d;
      txr_q  <= txr_d;
      rxv_q  <= rxv_d;
      rxd_q  <= rxd_d;
    end
  end

  assign addr_done   = done_q;
  assign addr_hit    = hit_q;
  assign tx_ready    = txr_q;
  assign rx_valid    = rxv_q;
  assign rx_data     = rxd_q;
  assign rx_overflow = ovf_q;

endmodule : serial_engine

// ### hw/serial_engine_map.svh
// Constants for the serial engine front end and its address matcher.
// Assumes a single 50 MHz system clock and no software-visible register bus.
//
// Behaviour
// - The transmit path holds one write buffer word ahead of the transmit shift register.
// - The receive path holds two completed words in a buffer behind the receive shift register.
// - The baud generator runs from the engine core clock or from an external clock, as configured.
// - Address comparison is present and active in the SPI and I2C operating modes.
// - The matcher offers single address, two addresses, or address with bit mask.
// - The comparison uses seven or eight address bits depending on the protocol mode.
// - In masked mode every bit set in the mask field is left out of the comparison.
// - An all-zero mask matches only addresses equal to the stored address in the compared bits (bit 7 is not compared in I2C mode).
// - An all-ones mask accepts every received address.
// - In two-address mode a match is either the address field or the mask field value.
`ifndef SERIAL_ENGINE_MAP_SVH
`define SERIAL_ENGINE_MAP_SVH

`define DATA_W        8
`define ADDR_W        8
`define BAUD_W        16
`define BIT_CNT_W     4
`define MODE_W        3
`define AMODE_W       2
`define MODE_USART    3'h1
`define MODE_SPI      3'h3
`define MODE_I2C      3'h5
`define AMODE_MASK    2'h0
`define AMODE_TWO     2'h1
`define AMODE_SINGLE  2'h2
`define AMODE_NONE    2'h3
`define TX_LAST_CNT   4'h8
`define RX_LAST_CNT   4'h7
`define I2C_ADDR_MSK  8'h7F
`define FULL_ADDR_MSK 8'hFF
`define BAUD_RESET    16'h0000

`endif

// ### hw/serial_engine_pkg.sv
// Types for the serial engine front end.
// Assumes the constant header is compiled alongside.
package serial_engine_pkg;

  typedef enum logic [1:0]
  {
    SH_IDLE = 2'b00,
    SH_BUSY = 2'b01,
    SH_LAST = 2'b11
  } shift_state_t;

endpackage : serial_engine_pkg

// ### hw/address_matcher.sv
// Address compare unit for SPI and I2C modes.
// Assumes address, mask and mode are stable while a received address is strobed.
`timescale 1ns/1ps
`include "serial_engine_map.svh"

module address_matcher
(
  // Configuration
  input  wire logic [`MODE_W-1:0]  mode,
  input  wire logic [`AMODE_W-1:0] addr_mode,
  input  wire logic [`ADDR_W-1:0]  match_addr_field,
  input  wire logic [`ADDR_W-1:0]  match_mask_field,
  // Received address
  input  wire logic [`ADDR_W-1:0]  rx_addr,
  // Result
  output logic                     hit
);

  logic [`ADDR_W-1:0] width_mask;
  logic               proto_ok;
  logic [`ADDR_W-1:0] diff_a;
  logic [`ADDR_W-1:0] diff_b;

  always_comb
  begin
    width_mask = (mode == `MODE_I2C) ? `I2C_ADDR_MSK : `FULL_ADDR_MSK;
    proto_ok   = (mode == `MODE_SPI) || (mode == `MODE_I2C);
    diff_a     = (rx_addr ^ match_addr_field) & width_mask;
    diff_b     = (rx_addr ^ match_mask_field) & width_mask;
    hit        = 1'b0;
    unique case (addr_mode)
      `AMODE_MASK:   hit = proto_ok && ((diff_a & ~match_mask_field) == '0);
      `AMODE_TWO:    hit = proto_ok && ((diff_a == '0) || (diff_b == '0));
      `AMODE_SINGLE: hit = proto_ok && (diff_a == '0);
      default:       hit = 1'b0;
    endcase
  end

endmodule : address_matcher

// ### verif/serial_peer_model.sv
// Behavioural serial peer: sends words on the receive line, captures transmit frames.
// Assumes one bit lasts BIT_CYC system clock cycles.
`timescale 1ns/1ps
module serial_peer_model
#(
  parameter int BIT_CYC = 4
)
(
  // Clock
  input  wire logic sys_clk,
  // Serial lines
  output logic      rx_line,
  output logic      rx_is_addr,
  input  wire logic tx_line
);
  initial
  begin
    rx_line    = 1'b1;
    rx_is_addr = 1'b0;
  end

  // Start low, eight bits lsb first, stop high, then idle high
  task automatic send(input logic [7:0] d, input logic a);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    @(posedge sys_clk);
    #1 rx_is_addr = a;
    for (int i = 0; i < 10; i++)
    begin
      rx_line = f[i];
      repeat (BIT_CYC) @(posedge sys_clk);
      #1;
    end
    repeat (2 * BIT_CYC) @(posedge sys_clk);
    #1 rx_is_addr = 1'b0;
  endtask : send

  // Samples each bit in its middle, start bit first
  task automatic recv(output logic [9:0] f);
    @(negedge tx_line);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++)
    begin
      if (i > 0)
        repeat (BIT_CYC) @(posedge sys_clk);
      #1 f[i] = tx_line;
    end
  endtask : recv
endmodule : serial_peer_model

// ### verif/serial_engine_chk.sv
// Concurrent checks on the serial engine ports.
// Assumes the constant header is on the include path.
`timescale 1ns/1ps
`include "serial_engine_map.svh"
module serial_engine_chk
(
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  // Configuration
  input wire logic [`MODE_W-1:0]   mode,
  input wire logic [`AMODE_W-1:0]  addr_mode,
  input wire logic [`ADDR_W-1:0]   match_mask_field,
  // Handshakes and results
  input wire logic                 tx_valid,
  input wire logic                 tx_ready,
  input wire logic                 rx_valid,
  input wire logic                 rx_pop,
  input wire logic                 rx_overflow,
  input wire logic                 addr_done,
  input wire logic                 addr_hit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire match_on = (mode == `MODE_SPI) || (mode == `MODE_I2C);
  wire mask_sel = match_on && (addr_mode == `AMODE_MASK);

  // ****************************************
  // Address result and buffer checks
  // ****************************************
  AST_DONE_ONE:
    assert property (addr_done |=> !addr_done) else $error("address done longer than one cycle");
  AST_HIT_WITH_DONE:
    assert property (!addr_done |-> $stable(addr_hit)) else $error("hit changed without done");
  AST_OFF_MODE:
    assert property (addr_done && !match_on |-> !addr_hit) else $error("hit outside SPI and I2C");
  AST_ALL_ONES:
    assert property (addr_done && mask_sel && match_mask_field == `FULL_ADDR_MSK |-> addr_hit)
      else $error("full mask did not match");
  AST_I2C_SEVEN:
    assert property (addr_done && mask_sel && mode == `MODE_I2C && match_mask_field == `I2C_ADDR_MSK |-> addr_hit)
      else $error("I2C compared more than seven bits");
  AST_NO_SCHEME:
    assert property (addr_done && addr_mode == `AMODE_NONE |-> !addr_hit) else $error("hit in unused scheme");
  AST_TX_TAKE:
    assert property (tx_valid && tx_ready |-> ##[1:2] !tx_ready) else $error("write buffer not filled");
  AST_OVF_FULL:
    assert property ($rose(rx_overflow) |-> $past(rx_valid)) else $error("overflow with empty buffer");
  AST_RX_KEEP:
    assert property (rx_valid && !rx_pop |=> rx_valid) else $error("word lost without pop");
  cover property (addr_done && addr_hit);
  cover property (addr_done && !addr_hit);
  cover property ($rose(rx_overflow));
  cover property (tx_valid && tx_ready);
endmodule : serial_engine_chk

bind serial_engine serial_engine_chk u_chk (.sys_clk, .resetn, .mode, .addr_mode, .match_mask_field, .tx_valid,
  .tx_ready, .rx_valid, .rx_pop, .rx_overflow, .addr_done, .addr_hit);

// ### verif/serial_engine_address_match_tb_top.sv
// Self-checking bench for the serial engine front end.
// Assumes design, checker and peer model are compiled first.
`timescale 1ns/1ps
`include "serial_engine_map.svh"
module serial_engine_address_match_tb_top;
  logic                sys_clk, resetn, ext_clk_sel, ext_clk, tx_valid, tx_ready, tx_line;
  logic                rx_line, rx_is_addr, rx_valid, rx_pop, rx_overflow, addr_done, addr_hit;
  logic [`MODE_W-1:0]  mode;
  logic [`BAUD_W-1:0]  baud_div;
  logic [`AMODE_W-1:0] addr_mode;
  logic [`ADDR_W-1:0]  match_addr_field, match_mask_field;
  logic [`DATA_W-1:0]  tx_data, rx_data;
  int                  fail_count, comparisons;

  serial_engine u_dut (.sys_clk, .resetn, .mode, .ext_clk_sel, .ext_clk, .baud_div, .addr_mode, .match_addr_field,
    .match_mask_field, .tx_valid, .tx_data, .tx_ready, .tx_line, .rx_line, .rx_is_addr, .rx_valid, .rx_data,
    .rx_pop, .rx_overflow, .addr_done, .addr_hit);
  serial_peer_model #(.BIT_CYC(4)) u_peer (.sys_clk, .rx_line, .rx_is_addr, .tx_line);

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    ext_clk = 1'b0;
    #7;
    forever #40 ext_clk = ~ext_clk;
  end

  // ****************************************
  // Compare, handshake and scenario tasks
  // ****************************************
  task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({9'h000, got}, {9'h000, exp});
  endtask : cmp_bit
  task automatic final_report;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic push(input logic [7:0] d);
    @(posedge sys_clk);
    #1 tx_valid = 1'b1;
    tx_data = d;
    while (tx_ready !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1 tx_valid = 1'b0;
  endtask : push
  task automatic wait_done(output logic hit);
    int n;
    n = 0;
    while (addr_done !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    hit = (n < 200) ? addr_hit : 1'bx;
  endtask : wait_done

  // Fields: mode, scheme, address, mask, received, expected
  task automatic check_match;
    logic [35:0] tbl [14] = '{36'h3_0_5A_00_5A_1, 36'h3_0_5A_00_5B_0, 36'h3_0_5A_0F_53_1, 36'h3_0_5A_0F_4A_0,
      36'h3_0_5A_FF_A5_1, 36'h3_1_12_34_34_1, 36'h3_1_12_34_12_1, 36'h3_1_12_34_56_0, 36'h3_2_77_00_77_1,
      36'h3_2_77_00_F7_0, 36'h5_2_77_00_F7_1, 36'h5_0_00_7F_80_1, 36'h1_2_77_00_77_0, 36'h3_3_77_00_77_0};
    logic got;
    foreach (tbl[i])
    begin
      mode = tbl[i][34:32];
      addr_mode = tbl[i][29:28];
      match_addr_field = tbl[i][27:20];
      match_mask_field = tbl[i][19:12];
      fork
        u_peer.send(tbl[i][11:4], 1'b1);
        wait_done(got);
      join
      cmp_bit(got, tbl[i][0]);
    end
  endtask : check_match

  task automatic check_rx_buffer;
    logic [7:0] d [3] = '{8'hA1, 8'h5C, 8'h3E};
    mode = `MODE_SPI;
    foreach (d[i])
      u_peer.send(d[i], 1'b0);
    repeat (8) @(posedge sys_clk);
    #1 cmp_bit(rx_overflow, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      cmp_word({2'b00, rx_data}, {2'b00, d[i]});
      rx_pop = 1'b1;
      @(posedge sys_clk);
      #1 rx_pop = 1'b0;
      @(posedge sys_clk);
      #1;
    end
    cmp_bit(rx_valid, 1'b0);
    cmp_bit(rx_overflow, 1'b0);
  endtask : check_rx_buffer

  // A slow internal divider proves the external clock really drives the bits
  task automatic check_tx(input logic ext);
    logic [9:0] f0, f1;
    ext_clk_sel = ext;
    baud_div = ext ? 16'hFFFF : 16'h0003;
    fork
      begin
        cmp_bit(tx_ready, 1'b1);
        push(8'h96);
        cmp_bit(tx_ready, 1'b0);
        push(8'h3B);
      end
      begin
        u_peer.recv(f0);
        u_peer.recv(f1);
      end
    join
    cmp_word(f0, {1'b1, 8'h96, 1'b0});
    cmp_word(f1, {1'b1, 8'h3B, 1'b0});
  endtask : check_tx

  initial
  begin
    fail_count = 0;
    comparisons = 0;
    resetn = 1'b0;
    mode = `MODE_SPI;
    ext_clk_sel = 1'b0;
    baud_div = 16'h0003;
    addr_mode = `AMODE_SINGLE;
    match_addr_field = 8'h00;
    match_mask_field = 8'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_pop = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1'b1;
    check_match();
    check_rx_buffer();
    check_tx(1'b0);
    check_tx(1'b1);
    final_report();
  end
  initial
  begin
    repeat (8000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end
endmodule : serial_engine_address_match_tb_top
